// ===== core/frame_rx_pkg.sv
//------------------------------------------------------------------------------
// Constants for the serial frame receiver with XON/XOFF flow control
//------------------------------------------------------------------------------
// Holds the register map, field positions, reset values and timing counts.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
//
// Overview of operation
// - Timeout mode: line pause closes the frame
// - End char: single, pair in sequence, either
// - End char frame keeps its terminators
// - No terminator before pause: error, drop fragment
// - Tail after terminator dropped or joins next
// - Unterminated burst dropped or joins next
// - Fixed mode closes frame at configured count
// - Fixed mode early pause: error, drop fragment
// - Extra chars dropped or carried onward
// - Short burst dropped or merged with next
// - Timeout and fixed modes are byte transparent with flow control off
// - Store holds 2000 bytes as a ring
// - Overwrite protection and 1..10 frame limit
// - Store cleared at start or by command
// - Oldest stored frame is handed out first
// - Limit 1 unprotected keeps newest frame only
// - Entering flow control sends one XON
// - XOFF at frame limit or 50 free
// - Overflow after XOFF: error, drop frame
// - XON once host fetched and room exists
// - XOFF holds transmit; late XON aborts 0708H
// - Flow chars configurable, defaults 11H, 13H
// - Seven-bit frame masks characters to 7FH
`default_nettype none

package frame_rx_pkg;
   //---------------------------------------------------------------------------
   // Bus and register map
   //---------------------------------------------------------------------------
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_CHARS  = 8'h04;
   localparam logic [7:0]  OFS_TIMES  = 8'h08;
   localparam logic [7:0]  OFS_FIXLEN = 8'h0c;
   localparam logic [7:0]  OFS_CMD    = 8'h10;
   localparam logic [7:0]  OFS_STATUS = 8'h14;
   localparam logic [7:0]  OFS_HEAD   = 8'h18;
   localparam logic [7:0]  OFS_DATA   = 8'h1c;
   localparam logic [7:0]  OFS_FREE   = 8'h20;
   // Control fields
   localparam int CTL_RUN = 0;
   localparam int CTL_FLOW = 1;
   localparam int CTL_MODE = 2;
   localparam int CTL_SEL = 4;
   localparam int CTL_SEVEN = 6;
   localparam int CTL_PROT = 7;
   localparam int CTL_CLRST = 8;
   localparam int CTL_LIMIT = 12;
   localparam int CMD_CLEAR = 0;
   localparam int ST_RXERR = 8;
   localparam int ST_OVF = 9;
   localparam int ST_HOLD = 10;
   localparam int ST_PAUSE = 11;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [31:0] CHARS_RST = 32'h1311_0000;
   localparam logic [31:0] TIMES_RST = 32'h03e8_0064;
   localparam logic [10:0] FIXLEN_RST = 11'h001;
   //---------------------------------------------------------------------------
   // Storage sizes
   //---------------------------------------------------------------------------
   localparam logic [10:0] STORE_BYTES = 11'd2000;
   localparam logic [10:0] FREE_MARGIN = 11'd50;
   localparam logic [4:0]  FRAME_SLOTS = 5'd16;
   localparam logic [4:0]  LIMIT_MAX   = 5'd10;
   localparam logic [15:0] ABORT_CODE  = 16'h0708;
   //---------------------------------------------------------------------------
   // Timing
   //---------------------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int US_NS = 1000;
   localparam logic [6:0] US_CYC = 7'(US_NS / CLK_NS);
   localparam logic [9:0] MS_US = 10'd1000;

   typedef enum logic [1:0] {END_TIMEOUT, END_CHAR, END_FIXED} end_mode_type;
endpackage

`default_nettype wire

// ===== core/serial_frame_rx.sv
//------------------------------------------------------------------------------
// Serial frame receiver with ring store and XON/XOFF flow control
//------------------------------------------------------------------------------
// Characters arrive from a UART as one-cycle strobes; the transmitter takes
// each flow strobe in the cycle it is given and obeys the hold level.
`default_nettype none

module serial_frame_rx (
   input  wire logic                           i_clock,
   input  wire logic                           i_rst,
   input  wire logic                           i_psel,
   input  wire logic                           i_penable,
   input  wire logic                           i_pwrite,
   input  wire logic [frame_rx_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]                    i_pwdata,
   output logic      [31:0]                    o_prdata,
   output logic                                o_pready,
   output logic                                o_pslverr,
   input  wire logic                           i_rx_valid,
   input  wire logic [7:0]                     i_rx_data,
   output logic                                o_flow_valid,
   output logic      [7:0]                     o_flow_char,
   output logic                                o_tx_hold,
   output logic                                o_tx_abort
);
   import frame_rx_pkg::*;

   //---------------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------------
   // Ring pointer step, both operands below the store size
   function automatic logic [10:0] ring_add(input logic [10:0] a, input logic [10:0] b);
      logic [11:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, STORE_BYTES}) begin
         s = s - {1'b0, STORE_BYTES};
      end
      return s[10:0];
   endfunction

   //---------------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------------
   logic [15:0]  ctrl_r;
   logic [31:0]  chars_r;
   logic [31:0]  times_r;
   logic [10:0]  fixlen_r;
   logic [7:0]   mem_r [0:2047];
   logic [10:0]  len_r [0:15];
   logic [10:0]  rd_ptr_r, fs_ptr_r, cur_len_r, bytes_r, rd_off_r;
   logic [3:0]   head_r, tail_r;
   logic [4:0]   count_r;
   logic         prev_e1_r, run_prev_r, flow_prev_r, paused_r;
   logic         rx_err_r, ovf_r;
   logic [15:0]  code_r, cd_cnt_r, xw_cnt_r;
   logic [6:0]   us_cnt_r;
   logic [9:0]   ms_cnt_r;
   logic         us_tick, ms_tick;
   end_mode_type mode;
   logic [7:0]   rx_byte, e1, e2, xon_c, xoff_c;
   logic         acc, wr_en, rd_cap, clr, is_flow, store_ch, full_b, hit, term;
   logic         expire, commit_ch, commit, reject, accept, drop_old, drop_to;
   logic         overflow_ev, pop, pop_last, slots_full, want_pause, flow_on;
   logic [10:0]  commit_len, used, head_len, rem, free_b, cur_inc;
   logic [4:0]   eff_limit;

   //---------------------------------------------------------------------------
   // Field decode
   //---------------------------------------------------------------------------
   // Undefined mode code falls back to plain timeout framing
   always_comb begin
      case (ctrl_r[CTL_MODE+:2])
         2'h1: mode = END_CHAR;
         2'h2: mode = END_FIXED;
         default: mode = END_TIMEOUT;
      endcase
   end
   assign e1 = chars_r[7:0];
   assign e2 = chars_r[15:8];
   assign xon_c = chars_r[23:16];
   assign xoff_c = chars_r[31:24];
   assign flow_on = ctrl_r[CTL_FLOW];
   // Zero limit means the whole slot table; larger codes clamp to ten
   assign eff_limit = (ctrl_r[CTL_LIMIT+:4] == 4'h0) ? FRAME_SLOTS :
                      ({1'b0, ctrl_r[CTL_LIMIT+:4]} > LIMIT_MAX) ? LIMIT_MAX :
                      {1'b0, ctrl_r[CTL_LIMIT+:4]};

   //---------------------------------------------------------------------------
   // APB slave: one wait state, reads captured as pready rises
   //---------------------------------------------------------------------------
   assign acc = i_psel & i_penable;
   assign wr_en = acc & o_pready & i_pwrite;
   assign rd_cap = acc & ~o_pready & ~i_pwrite;

   // Ready pulse and error answer for unmapped offsets
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= acc & ~o_pready;
         o_pslverr <= acc & ~o_pready & (i_paddr > OFS_FREE || i_paddr[1:0] != 2'h0);
      end
   end

   // Read data; a data read pops the byte it returns
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_cap) begin
         case (i_paddr)
            OFS_CTRL:   o_prdata <= {16'h0000, ctrl_r};
            OFS_CHARS:  o_prdata <= chars_r;
            OFS_TIMES:  o_prdata <= times_r;
            OFS_FIXLEN: o_prdata <= {21'h000000, fixlen_r};
            OFS_STATUS: o_prdata <= {code_r, 4'h0, paused_r, o_tx_hold, ovf_r, rx_err_r,
                                     3'h0, count_r};
            OFS_HEAD:   o_prdata <= {21'h000000, (count_r != 5'h00) ? head_len : 11'h000};
            OFS_DATA:   o_prdata <= {23'h000000, count_r != 5'h00, mem_r[rd_ptr_r]};
            OFS_FREE:   o_prdata <= {21'h000000, free_b};
            default:    o_prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_r <= CTRL_RST;
         chars_r <= CHARS_RST;
         times_r <= TIMES_RST;
         fixlen_r <= FIXLEN_RST;
      end else if (wr_en) begin
         case (i_paddr)
            OFS_CTRL:   ctrl_r <= i_pwdata[15:0];
            OFS_CHARS:  chars_r <= i_pwdata;
            OFS_TIMES:  times_r <= i_pwdata;
            OFS_FIXLEN: fixlen_r <= i_pwdata[10:0];
            default:    ;
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Time base: microsecond and millisecond enables
   //---------------------------------------------------------------------------
   assign us_tick = (us_cnt_r == US_CYC - 7'd1);
   assign ms_tick = us_tick & (ms_cnt_r == MS_US - 10'd1);
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         us_cnt_r <= 7'h00;
         ms_cnt_r <= 10'h000;
      end else begin
         us_cnt_r <= us_tick ? 7'h00 : us_cnt_r + 7'd1;
         if (us_tick) begin
            ms_cnt_r <= ms_tick ? 10'h000 : ms_cnt_r + 10'd1;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Character classification and frame end detection
   //---------------------------------------------------------------------------
   assign rx_byte = ctrl_r[CTL_SEVEN] ? {1'b0, i_rx_data[6:0]} : i_rx_data;
   // Flow chars are swallowed while flow is on, so no framing mode is transparent then
   assign is_flow = flow_on & (rx_byte == xon_c | rx_byte == xoff_c);
   assign store_ch = i_rx_valid & ctrl_r[CTL_RUN] & ~is_flow;
   assign used = bytes_r + cur_len_r;
   assign free_b = STORE_BYTES - used;
   assign full_b = (used == STORE_BYTES);
   assign cur_inc = cur_len_r + 11'd1;

   // Terminator match: single, pair in order, or either of two
   always_comb begin
      case (ctrl_r[CTL_SEL+:2])
         2'h1: hit = prev_e1_r & (rx_byte == e2);
         2'h2: hit = (rx_byte == e1) | (rx_byte == e2);
         default: hit = (rx_byte == e1);
      endcase
   end

   // Timeout mode never matches content, so any byte is carried
   always_comb begin
      case (mode)
         END_CHAR:  term = hit;
         END_FIXED: term = (cur_inc == fixlen_r);
         default:   term = 1'b0;
      endcase
   end

   // Pause timer runs only inside a frame and restarts per stored character
   assign expire = (cur_len_r != 11'h000) & us_tick & ~store_ch &
                   (cd_cnt_r + 16'd1 >= times_r[15:0]);
   always_ff @(posedge i_clock) begin
      if (i_rst || store_ch || cur_len_r == 11'h000) begin
         cd_cnt_r <= 16'h0000;
      end else if (us_tick) begin
         cd_cnt_r <= cd_cnt_r + 16'd1;
      end
   end

   assign overflow_ev = store_ch & full_b;
   assign commit_ch = store_ch & ~full_b & term;
   assign commit = commit_ch | (expire & mode == END_TIMEOUT);
   // Pause in the other modes discards fragment and any tail
   assign drop_to = expire & mode != END_TIMEOUT;
   assign commit_len = commit_ch ? cur_inc : cur_len_r;
   assign slots_full = (count_r >= eff_limit);
   assign reject = commit & slots_full & ctrl_r[CTL_PROT];
   assign accept = commit & ~reject;
   assign drop_old = accept & slots_full;

   //---------------------------------------------------------------------------
   // Host side of the ring
   //---------------------------------------------------------------------------
   assign head_len = len_r[head_r];
   assign rem = head_len - rd_off_r;
   assign pop = rd_cap & (i_paddr == OFS_DATA) & (count_r != 5'h00);
   assign pop_last = pop & (rd_off_r + 11'd1 == head_len);
   assign clr = (wr_en & i_paddr == OFS_CMD & i_pwdata[CMD_CLEAR]) |
                (ctrl_r[CTL_RUN] & ~run_prev_r & ctrl_r[CTL_CLRST]);

   // Byte store; written beyond the committed tail until the frame closes
   always_ff @(posedge i_clock) begin
      if (store_ch && !full_b) begin
         mem_r[ring_add(fs_ptr_r, cur_len_r)] <= rx_byte;
      end
   end

   // Frame and pointer bookkeeping
   always_ff @(posedge i_clock) begin
      if (i_rst || clr) begin
         rd_ptr_r <= 11'h000;
         fs_ptr_r <= 11'h000;
         cur_len_r <= 11'h000;
         bytes_r <= 11'h000;
         rd_off_r <= 11'h000;
         head_r <= 4'h0;
         tail_r <= 4'h0;
         count_r <= 5'h00;
         prev_e1_r <= 1'b0;
      end else begin
         // Bursts without an end are discarded at the pause or on overflow
         if (commit || drop_to || overflow_ev) begin
            cur_len_r <= 11'h000;
            prev_e1_r <= 1'b0;
         end else if (store_ch) begin
            cur_len_r <= cur_inc;
            prev_e1_r <= (rx_byte == e1);
         end
         if (accept) begin
            fs_ptr_r <= ring_add(fs_ptr_r, commit_len);
            len_r[tail_r] <= commit_len;
            tail_r <= tail_r + 4'd1;
         end
         // Dropping the oldest wins over a host pop in the same cycle
         if (drop_old) begin
            rd_ptr_r <= ring_add(rd_ptr_r, rem);
            head_r <= head_r + 4'd1;
            rd_off_r <= 11'h000;
         end else if (pop) begin
            rd_ptr_r <= ring_add(rd_ptr_r, 11'd1);
            head_r <= pop_last ? head_r + 4'd1 : head_r;
            rd_off_r <= pop_last ? 11'h000 : rd_off_r + 11'd1;
         end
         count_r <= count_r + {4'h0, accept} - {4'h0, drop_old | pop_last};
         bytes_r <= bytes_r + (accept ? commit_len : 11'h000) -
                    (drop_old ? rem : {10'h000, pop});
      end
   end

   // Sticky errors, write one to clear; a new event wins over the clear
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rx_err_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         rx_err_r <= drop_to |
                     (rx_err_r & ~(wr_en & i_paddr == OFS_STATUS & i_pwdata[ST_RXERR]));
         ovf_r <= overflow_ev | reject |
                  (ovf_r & ~(wr_en & i_paddr == OFS_STATUS & i_pwdata[ST_OVF]));
      end
   end

   //---------------------------------------------------------------------------
   // Flow control toward the partner
   //---------------------------------------------------------------------------
   assign want_pause = (ctrl_r[CTL_LIMIT+:4] != 4'h0 & slots_full) |
                       (free_b <= FREE_MARGIN);

   // Start XON first; pause and resume are edge driven, one char each
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_flow_valid <= 1'b0;
         o_flow_char <= 8'h00;
         paused_r <= 1'b0;
         flow_prev_r <= 1'b0;
         run_prev_r <= 1'b0;
      end else begin
         flow_prev_r <= flow_on;
         run_prev_r <= ctrl_r[CTL_RUN];
         o_flow_valid <= 1'b0;
         if (flow_on && !flow_prev_r) begin
            o_flow_valid <= 1'b1;
            o_flow_char <= xon_c;
            paused_r <= 1'b0;
         end else if (flow_on && want_pause && !paused_r) begin
            o_flow_valid <= 1'b1;
            o_flow_char <= xoff_c;
            paused_r <= 1'b1;
         end else if (flow_on && !want_pause && paused_r) begin
            o_flow_valid <= 1'b1;
            o_flow_char <= xon_c;
            paused_r <= 1'b0;
         end else if (!flow_on) begin
            paused_r <= 1'b0;
         end
      end
   end

   // Transmit hold on partner XOFF, aborted if XON is too late
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_tx_hold <= 1'b0;
         o_tx_abort <= 1'b0;
         xw_cnt_r <= 16'h0000;
         code_r <= 16'h0000;
      end else begin
         o_tx_abort <= 1'b0;
         if (wr_en && i_paddr == OFS_STATUS && i_pwdata[ST_HOLD]) begin
            code_r <= 16'h0000;
         end
         if (i_rx_valid && flow_on && rx_byte == xoff_c) begin
            o_tx_hold <= 1'b1;
            xw_cnt_r <= 16'h0000;
         end else if (i_rx_valid && flow_on && rx_byte == xon_c) begin
            o_tx_hold <= 1'b0;
         end else if (o_tx_hold && ms_tick) begin
            if (xw_cnt_r + 16'd1 >= times_r[31:16]) begin
               o_tx_hold <= 1'b0;
               o_tx_abort <= 1'b1;
               code_r <= ABORT_CODE;
            end else begin
               xw_cnt_r <= xw_cnt_r + 16'd1;
            end
         end
      end
   end

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   fixed_len_a: assert property (commit_ch && mode == END_FIXED |-> commit_len == fixlen_r)
      else $error("fixed frame closed at wrong length");
   frag_drop_a: assert property (drop_to && !clr |=> cur_len_r == 11'h000 && rx_err_r)
      else $error("fragment not dropped with error");
   store_cap_a: assert property (used <= STORE_BYTES)
      else $error("store exceeds capacity");
   newest_only_a: assert property (eff_limit == 5'd1 && !ctrl_r[CTL_PROT] && count_r == 5'd1
                                   && accept && !clr |=> count_r == 5'd1)
      else $error("limit one did not replace frame");
   start_xon_a: assert property (flow_on && !flow_prev_r |=> o_flow_valid && o_flow_char == xon_c)
      else $error("no XON on flow enable");
   pause_xoff_a: assert property ($rose(paused_r) |-> o_flow_valid && o_flow_char == xoff_c)
      else $error("pause without XOFF");
   abort_code_a: assert property (o_tx_abort |-> code_r == ABORT_CODE && !o_tx_hold)
      else $error("abort without status code");
   flow_skip_a: assert property (i_rx_valid && is_flow && !expire && !clr
                                 |=> cur_len_r == $past(cur_len_r))
      else $error("flow char stored");
   pready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("pready held two cycles");

   frame_end_c: cover property (commit_ch ##[1:50] pop_last);
   overwrite_c: cover property (drop_old);
   tx_abort_c: cover property (o_tx_hold ##[1:1000] o_tx_abort);
   overflow_c: cover property (overflow_ev);
endmodule

`default_nettype wire

// ===== dv/serial_partner.sv
// Remote serial partner: sends characters as strobes, obeys XON/XOFF.
// Assumes the receiver emits flow characters as one-cycle pulses.
`default_nettype none
module serial_partner #(
   parameter logic [7:0] RESUME = 8'h11,
   parameter logic [7:0] PAUSE  = 8'h13
) (
   input  wire logic       i_clock,
   input  wire logic       i_flow_valid,
   input  wire logic [7:0] i_flow_char,
   output logic            o_valid,
   output logic      [7:0] o_data,
   output logic            o_paused,
   output logic      [7:0] o_last_flow
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_valid = 1'b0;
      o_data = 8'h00;
      o_paused = 1'b0;
      o_last_flow = 8'h00;
   end
   // Track flow characters from the receiver
   always @(posedge i_clock) begin
      if (i_flow_valid) begin
         o_last_flow <= i_flow_char;
         if (i_flow_char == PAUSE) o_paused <= 1'b1;
         if (i_flow_char == RESUME) o_paused <= 1'b0;
      end
   end
   // One character; line data inverted when idle so no stale value shows
   task automatic send(input logic [7:0] b);
      while (o_paused) @(posedge i_clock);
      @(posedge i_clock);
      o_valid <= 1'b1;
      o_data <= b;
      @(posedge i_clock);
      o_valid <= 1'b0;
      o_data <= ~b;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench for the frame receiver: APB master, partner, scenario tasks.
// Assumes one wait state APB slave and a 100 MHz clock.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import frame_rx_pkg::*;
   // Bus signals start idle from the sequence below, not from declarations
   logic clk, rst, psel, pen, pwr;
   logic [7:0] padr, fch, lastf;
   logic [31:0] pwd, prd, q;
   logic pready, perr, e, rxv, fv, hold, abrt, paused;
   logic [7:0] rxd;
   int n_errors = 0, checked = 0;
   always #5 clk = ~clk;
   serial_frame_rx i_serial_frame_rx (.i_clock(clk), .i_rst(rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
      .o_pready(pready), .o_pslverr(perr), .i_rx_valid(rxv), .i_rx_data(rxd),
      .o_flow_valid(fv), .o_flow_char(fch), .o_tx_hold(hold), .o_tx_abort(abrt));
   serial_partner i_serial_partner (.i_clock(clk), .i_flow_valid(fv), .i_flow_char(fch),
      .o_valid(rxv), .o_data(rxd), .o_paused(paused), .o_last_flow(lastf));
   //---------------------------------------------------------------------------
   // Bus and compare tasks
   //---------------------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prd;
      e = perr;
      psel <= 0; pen <= 0;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
      checked++;
      if (s !== x) begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", nm, x, s);
      end
   endtask
   task automatic clr;
      apb(1, OFS_CMD, 32'h1);
      apb(0, OFS_HEAD, 0); chk("head after clear", 0, q);
   endtask
   //---------------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------------
   task automatic t_reset;
      apb(0, OFS_CHARS, 0); chk("chars", 32'h1311_0000, q);
      apb(0, OFS_FREE, 0); chk("free", 32'd2000, q);
      apb(0, 8'h24, 0); chk("slverr", 1, 32'(e));
      apb(1, OFS_TIMES, 32'h0001_0001);
      $display("test reset done");
   endtask
   task automatic t_fixed;
      apb(1, OFS_FIXLEN, 2);
      apb(1, OFS_CTRL, 32'h9);
      i_serial_partner.send(8'hff); i_serial_partner.send(8'h13);
      i_serial_partner.send(8'h5a); i_serial_partner.send(8'h11);
      apb(0, OFS_STATUS, 0); chk("count", 2, q & 32'h1f);
      apb(0, OFS_DATA, 0); chk("byte0", 32'h1ff, q);
      apb(0, OFS_DATA, 0); chk("byte1", 32'h113, q);
      apb(0, OFS_HEAD, 0); chk("next head", 2, q);
      clr;
      i_serial_partner.send(8'h01);
      repeat (400) @(posedge clk);
      apb(0, OFS_STATUS, 0); chk("early err", 32'h100, q & 32'h11f);
      apb(1, OFS_STATUS, 32'h300);
      // Limit one, unprotected, seven-bit: second frame replaces the first
      apb(1, OFS_CTRL, 32'h1049);
      i_serial_partner.send(8'h81);
      i_serial_partner.send(8'h82);
      i_serial_partner.send(8'hc1);
      i_serial_partner.send(8'hc2);
      apb(0, OFS_STATUS, 0); chk("newest count", 1, q & 32'h1f);
      apb(0, OFS_DATA, 0); chk("newest byte", 32'h141, q);
      clr;
      $display("test fixed done");
   endtask
   task automatic t_end_tmo;
      apb(1, OFS_CHARS, 32'h1311_000d);
      apb(1, OFS_CTRL, 32'h5);
      i_serial_partner.send(8'h41); i_serial_partner.send(8'h0d);
      apb(0, OFS_HEAD, 0); chk("end head", 2, q);
      // Fragment with no terminator is dropped with an error at the pause
      i_serial_partner.send(8'h41);
      repeat (200) @(posedge clk);
      apb(0, OFS_STATUS, 0); chk("end err", 32'h101, q & 32'h11f);
      apb(1, OFS_STATUS, 32'h100);
      clr;
      apb(1, OFS_CTRL, 32'h1);
      repeat (3) i_serial_partner.send(8'h0d);
      apb(0, OFS_HEAD, 0); chk("open frame", 0, q);
      repeat (400) @(posedge clk);
      apb(0, OFS_HEAD, 0); chk("tmo head", 3, q);
      clr;
      $display("test end and timeout done");
   endtask
   task automatic t_flow;
      apb(1, OFS_FIXLEN, 1);
      apb(1, OFS_CTRL, 32'h100b);
      repeat (4) @(posedge clk);
      chk("xon at start", 8'h11, lastf);
      i_serial_partner.send(8'h13);
      repeat (3) @(posedge clk);
      chk("hold", 1, 32'(hold));
      i_serial_partner.send(8'h11);
      repeat (3) @(posedge clk);
      chk("hold off", 0, 32'(hold));
      apb(0, OFS_HEAD, 0); chk("flow not stored", 0, q);
      i_serial_partner.send(8'h77);
      repeat (4) @(posedge clk);
      chk("xoff", 1, 32'(paused));
      apb(0, OFS_DATA, 0); chk("pop", 32'h177, q);
      repeat (4) @(posedge clk);
      chk("xon again", 0, 32'(paused));
      $display("test flow done");
   endtask
   //---------------------------------------------------------------------------
   // Sequence, watchdog and verdict
   //---------------------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      padr = 8'h00;
      pwd = 32'h0000_0000;
      repeat (4) @(posedge clk);
      rst <= 0;
      t_reset;
      t_fixed;
      t_end_tmo;
      t_flow;
      close_out;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      close_out;
   end
endmodule
`default_nettype wire
